// ===== tsa_pkg.sv
//------------------------------------------------------------------
// Purpose : shared constants and types for the sensor front end
// Assumes : 16-bit left-justified temperature words
//------------------------------------------------------------------
package tsa_pkg;

    //------------------------------------------------------------
    // Register pointers
    //------------------------------------------------------------
    localparam logic [1:0]  PTR_TEMP      = 2'h0;
    localparam logic [1:0]  PTR_CFG       = 2'h1;
    localparam logic [1:0]  PTR_HYSTERESIS_THRESHOLD      = 2'h2;
    localparam logic [1:0]  PTR_TOS       = 2'h3;

    //------------------------------------------------------------
    // Configuration fields and reset values
    //------------------------------------------------------------
    localparam int          CFG_SD        = 0;
    localparam int          CFG_MODE      = 1;
    localparam int          CFG_POL       = 2;
    localparam int          CFG_FT_LO     = 3;
    localparam int          CFG_FT_HI     = 4;
    localparam int          CFG_RES_LO    = 5;
    localparam int          CFG_RES_HI    = 6;
    localparam logic [7:0]  CFG_RST       = 8'h00;
    localparam logic [15:0] TOS_RST       = 16'h5000;
    localparam logic [15:0] HYSTERESIS_THRESHOLD_RST      = 16'h4b00;
    localparam logic [15:0] TEMP_RST      = 16'h0000;
    localparam logic [15:0] RES_MASK_BASE = 16'h007f;
    localparam logic [3:0]  PAD_ZERO      = 4'h0;
    localparam int          ADC_W         = 12;

    //------------------------------------------------------------
    // Fault queue lengths
    //------------------------------------------------------------
    localparam logic [2:0]  FAULT_N1      = 3'h1;
    localparam logic [2:0]  FAULT_N2      = 3'h2;
    localparam logic [2:0]  FAULT_N4      = 3'h4;
    localparam logic [2:0]  FAULT_N6      = 3'h6;

    //------------------------------------------------------------
    // Link framing and pins
    //------------------------------------------------------------
    localparam logic [3:0]  ADDR_HI       = 4'h9;
    localparam logic [3:0]  BIT_LAST      = 4'h7;
    localparam logic [3:0]  BIT_ACK       = 4'h8;
    localparam logic [1:0]  IDX_MAX       = 2'h2;
    localparam int          PIN_W         = 5;
    localparam int          PIN_SCL       = 4;
    localparam int          PIN_SDA       = 3;

    //------------------------------------------------------------
    // Conversion timebase
    //------------------------------------------------------------
    localparam int          CONV_W        = 24;
    localparam int          CONV_BASE_DEF = 1000000;
    localparam logic [CONV_W-1:0] CONV_ONE = 24'h000001;

    typedef enum logic [1:0] {
        I_IDLE = 2'b00,
        I_ADDR = 2'b01,
        I_WR   = 2'b11,
        I_RD   = 2'b10
    } tsa_i2c_e;

    typedef enum logic {
        A_HI = 1'b0,
        A_LO = 1'b1
    } tsa_alarm_e;

endpackage

// ===== tsa_sync.sv
//------------------------------------------------------------------
// Purpose : two-flop synchroniser for pin levels
// Assumes : inputs change slowly against clock_in
// Notes   : no reset, levels settle within two edges
//------------------------------------------------------------------
`timescale 1ns/10ps
module tsa_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input  wire logic             clock_in,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } tsa_sync_s;

    tsa_sync_s sy_reg;
    tsa_sync_s sy_next;

    // First stage feeds only the second
    always_comb begin
        sy_next.meta   = async_in;
        sy_next.stable = sy_reg.meta;
    end

    always_ff @(posedge clock_in) begin
        sy_reg <= sy_next;
    end

    assign sync_out = sy_reg.stable;
endmodule

// ===== tsa_scl_shift.sv
//------------------------------------------------------------------
// Purpose : shift register on the link clock
// Assumes : data line stable while the link clock is high
// Notes   : word stays still for a whole bit time after each edge
//------------------------------------------------------------------
`timescale 1ns/10ps
module tsa_scl_shift (
    // Link clock
    input  wire logic       scl_clk_in,
    // Serial data
    input  wire logic       sda_in,
    output logic      [7:0] byte_out
);
    typedef struct packed {
        logic [7:0] shift;
    } tsa_shift_s;

    tsa_shift_s sh_reg;
    tsa_shift_s sh_next;

    // Sample on the rising edge, the bit-valid point
    always_comb begin
        sh_next.shift = {sh_reg.shift[6:0], sda_in};
    end

    // Clock may stop between frames, so no reset is relied on
    always_ff @(posedge scl_clk_in) begin
        sh_reg <= sh_next;
    end

    assign byte_out = sh_reg.shift;
endmodule

// ===== tsa_top.sv
//------------------------------------------------------------------
// Purpose : temperature front end with two-wire slave and alert
// Assumes : converter code arrives on clock_in, pins idle high
// Notes   : bits shift in on the link clock, framing on clock_in
//------------------------------------------------------------------
`timescale 1ns/10ps
module tsa_top #(
    parameter int CONV_BASE_CYCLES = tsa_pkg::CONV_BASE_DEF
) (
    // System
    input  wire logic                       clock_in,
    input  wire logic                       sys_rst_in,
    // Two-wire link
    input  wire logic                       scl_clk_in,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe_out,
    // Address straps
    input  wire logic                       addr_strap_bit0_in,
    input  wire logic                       addr_strap_bit1_in,
    input  wire logic                       addr_strap_bit2_in,
    // Converter
    output logic                            conv_start_out,
    input  wire logic [tsa_pkg::ADC_W-1:0]  adc_data_in,
    // Alert pin
    output logic                            alert_output_out,
    output logic                            alert_output_oe_out,
    // Status
    output logic      [15:0]                temp_out,
    output logic      [7:0]                 config_out,
    output logic                            alert_active_out
);
    import tsa_pkg::*;

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    typedef struct packed {
        tsa_i2c_e          i2c_st;
        logic [3:0]        bit_cnt;
        logic [1:0]        byte_idx;
        logic [1:0]        ptr;
        logic              ack_due;
        logic [7:0]        tx;
        logic [7:0]        msb_hold;
        logic              scl_prev;
        logic              sda_prev;
        logic              sda_oe;
        logic              pull_lvl;
        logic [7:0]        cfg;
        logic [15:0]       over_limit_threshold;
        logic [15:0]       hysteresis_threshold;
        logic [15:0]       temp;
        logic [CONV_W-1:0] conv_cnt;
        logic              conv_busy;
        logic              conv_start;
        logic              read_clr;
        tsa_alarm_e        alarm_st;
        logic [2:0]        fault_cnt;
        logic              alert_act;
        logic              alert_oe;
    } tsa_top_s;

    // Reset image: alert released, counter cleared
    localparam tsa_top_s ST_RST = '{
        i2c_st   : I_IDLE,
        alarm_st : A_HI,
        scl_prev : 1'b1,
        sda_prev : 1'b1,
        cfg      : CFG_RST,
        over_limit_threshold      : TOS_RST,
        hysteresis_threshold     : HYSTERESIS_THRESHOLD_RST,
        temp     : TEMP_RST,
        default  : '0
    };

    tsa_top_s          st_reg;
    tsa_top_s          st_next;
    logic [PIN_W-1:0]  pins_sync;
    logic [7:0]        link_byte;
    logic              scl_s;
    logic              sda_s;
    logic [6:0]        own_addr;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    logic [1:0]        res;
    logic [15:0]       res_mask;
    logic [15:0]       sample;
    logic [15:0]       tos_m;
    logic [15:0]       hysteresis_threshold_m;
    logic [CONV_W-1:0] period;
    logic              new_res;
    logic              over;
    logic              under;
    logic              hit;
    logic              int_mode;
    logic [2:0]        fault_lim;

    //--------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------
    // Fault queue length from the two select bits
    function automatic logic [2:0] fault_limit(input logic [1:0] sel);
        case (sel)
            2'b00:   return FAULT_N1;
            2'b01:   return FAULT_N2;
            2'b10:   return FAULT_N4;
            default: return FAULT_N6;
        endcase
    endfunction

    // Byte presented to the master for a pointer
    function automatic logic [7:0] rd_byte(input logic [1:0] p,
                                           input logic lsb,
                                           input tsa_top_s s);
        logic [15:0] w;
        case (p)
            PTR_TEMP: w = s.temp;
            PTR_CFG:  w = {s.cfg, s.cfg};
            PTR_HYSTERESIS_THRESHOLD: w = s.hysteresis_threshold;
            default:  w = s.over_limit_threshold;
        endcase
        return lsb ? w[7:0] : w[15:8];
    endfunction

    //--------------------------------------------------------------
    // Pin capture and link clock domain
    //--------------------------------------------------------------
    // Oversampling at 25 MHz leaves margin at 400 kHz
    tsa_sync #(
        .WIDTH (PIN_W)
    ) u_pin_sync (
        .clock_in (clock_in),
        .async_in ({scl_clk_in, sda_in, addr_strap_bit2_in,
                    addr_strap_bit1_in, addr_strap_bit0_in}),
        .sync_out (pins_sync)
    );

    // Word read here only after a synchronised rising edge
    tsa_scl_shift u_scl_shift (
        .scl_clk_in (scl_clk_in),
        .sda_in     (sda_in),
        .byte_out   (link_byte)
    );

    assign scl_s    = pins_sync[PIN_SCL];
    assign sda_s    = pins_sync[PIN_SDA];
    assign own_addr = {ADDR_HI, pins_sync[2:0]};

    // Frame edges from the synchronised pins
    assign scl_rise  = scl_s && !st_reg.scl_prev;
    assign scl_fall  = !scl_s && st_reg.scl_prev;
    assign start_det = scl_s && st_reg.scl_prev &&
                       st_reg.sda_prev && !sda_s;
    assign stop_det  = scl_s && st_reg.scl_prev &&
                       !st_reg.sda_prev && sda_s;

    //--------------------------------------------------------------
    // Conversion and compare datapath
    //--------------------------------------------------------------
    // Unused low bits read as zero at coarse resolutions
    assign res      = st_reg.cfg[CFG_RES_HI:CFG_RES_LO];
    assign res_mask = ~(RES_MASK_BASE >> res);
    assign sample   = {adc_data_in, PAD_ZERO} & res_mask;
    assign period   = CONV_W'(CONV_BASE_CYCLES) << res;
    assign new_res  = st_reg.conv_busy && (st_reg.conv_cnt == '0);
    // Thresholds compared at the active resolution only
    assign tos_m     = st_reg.over_limit_threshold & res_mask;
    assign hysteresis_threshold_m    = st_reg.hysteresis_threshold & res_mask;
    assign over      = $signed(sample) > $signed(tos_m);
    assign under     = $signed(sample) < $signed(hysteresis_threshold_m);
    assign int_mode  = st_reg.cfg[CFG_MODE];
    assign fault_lim = fault_limit(st_reg.cfg[CFG_FT_HI:CFG_FT_LO]);

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb begin
        st_next            = st_reg;
        hit                = 1'b0;
        st_next.conv_start = 1'b0;
        st_next.read_clr   = 1'b0;
        st_next.pull_lvl   = 1'b0;
        st_next.scl_prev   = scl_s;
        st_next.sda_prev   = sda_s;

        // Link framing; a repeated start restarts the frame
        if (start_det) begin
            st_next.i2c_st   = I_ADDR;
            st_next.bit_cnt  = '0;
            st_next.byte_idx = '0;
            st_next.ack_due  = 1'b0;
            st_next.sda_oe   = 1'b0;
        end else if (stop_det) begin
            st_next.i2c_st = I_IDLE;
            st_next.sda_oe = 1'b0;
        end else if (st_reg.i2c_st != I_IDLE) begin
            if (scl_rise) begin
                if (st_reg.bit_cnt == BIT_ACK) begin
                    st_next.bit_cnt = '0;
                    st_next.ack_due = 1'b0;
                    // Master answer after a byte we sent
                    if (st_reg.i2c_st == I_RD && !st_reg.ack_due) begin
                        if (sda_s) begin
                            st_next.i2c_st = I_IDLE;
                        end else begin
                            st_next.tx = rd_byte(st_reg.ptr, 1'b1, st_reg);
                        end
                    end
                end else begin
                    st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                    if (st_reg.bit_cnt == BIT_LAST) begin
                        case (st_reg.i2c_st)
                            I_ADDR: begin
                                if (link_byte[7:1] == own_addr) begin
                                    st_next.ack_due = 1'b1;
                                    if (link_byte[0]) begin
                                        st_next.i2c_st   = I_RD;
                                        st_next.tx       = rd_byte(st_reg.ptr,
                                                           1'b0, st_reg);
                                        st_next.read_clr = 1'b1;
                                    end else begin
                                        st_next.i2c_st = I_WR;
                                    end
                                end else begin
                                    st_next.i2c_st = I_IDLE;
                                end
                            end
                            I_WR: begin
                                st_next.ack_due = 1'b1;
                                if (st_reg.byte_idx != IDX_MAX) begin
                                    st_next.byte_idx = st_reg.byte_idx + 2'h1;
                                end
                                // First byte points, later bytes load
                                if (st_reg.byte_idx == 2'h0) begin
                                    st_next.ptr = link_byte[1:0];
                                end else if (st_reg.ptr == PTR_CFG) begin
                                    st_next.cfg = link_byte;
                                end else if (st_reg.byte_idx == 2'h1) begin
                                    st_next.msb_hold = link_byte;
                                end else if (st_reg.ptr == PTR_TOS) begin
                                    st_next.over_limit_threshold = {st_reg.msb_hold,
                                                   link_byte};
                                end else if (st_reg.ptr == PTR_HYSTERESIS_THRESHOLD) begin
                                    st_next.hysteresis_threshold = {st_reg.msb_hold,
                                                    link_byte};
                                end
                            end
                            default: begin
                                st_next.ack_due = st_reg.ack_due;
                            end
                        endcase
                    end
                end
            end else if (scl_fall) begin
                // Data line only ever pulled low or released
                if (st_reg.bit_cnt == BIT_ACK) begin
                    st_next.sda_oe = st_reg.ack_due;
                end else if (st_reg.i2c_st == I_RD) begin
                    st_next.sda_oe = ~st_reg.tx[3'h7 -
                                     st_reg.bit_cnt[2:0]];
                end else begin
                    st_next.sda_oe = 1'b0;
                end
            end
        end

        // Free-running timebase; shutdown lets the current one finish
        if (new_res) begin
            st_next.temp      = sample;
            st_next.conv_busy = 1'b0;
        end else if (st_reg.conv_busy) begin
            st_next.conv_cnt = st_reg.conv_cnt - CONV_ONE;
        end
        if ((!st_reg.conv_busy || new_res) && !st_reg.cfg[CFG_SD]) begin
            st_next.conv_busy  = 1'b1;
            st_next.conv_start = 1'b1;
            st_next.conv_cnt   = period - CONV_ONE;
        end

        // Comparator mode has no armed direction
        if (!int_mode) begin
            st_next.alarm_st = A_HI;
        end
        // Interrupt clears first; a same-cycle result is not compared while the alert was set
        if (int_mode && (st_reg.read_clr || st_reg.cfg[CFG_SD])) begin
            st_next.alert_act = 1'b0;
        end
        if (new_res) begin
            hit = (int_mode && st_next.alarm_st == A_LO) ? under : over;
            if (!st_reg.alert_act) begin
                if (hit) begin
                    if (st_reg.fault_cnt + 3'h1 == fault_lim) begin
                        st_next.alert_act = 1'b1;
                        st_next.fault_cnt = '0;
                        if (int_mode) begin
                            st_next.alarm_st = (st_next.alarm_st == A_HI) ?
                                               A_LO : A_HI;
                        end
                    end else begin
                        st_next.fault_cnt = st_reg.fault_cnt + 3'h1;
                    end
                end else begin
                    st_next.fault_cnt = '0;
                end
            end else if (!int_mode && under) begin
                st_next.alert_act = 1'b0;
                st_next.fault_cnt = '0;
            end
        end

        // Active-high polarity means released while alerting
        st_next.alert_oe = st_next.alert_act ^ st_next.cfg[CFG_POL];
    end

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    // Pins drive only a low level; the pull-up gives high
    assign sda_out             = st_reg.pull_lvl;
    assign sda_oe_out          = st_reg.sda_oe;
    assign alert_output_out    = st_reg.pull_lvl;
    assign alert_output_oe_out = st_reg.alert_oe;
    assign conv_start_out      = st_reg.conv_start;
    assign temp_out            = st_reg.temp;
    assign config_out          = st_reg.cfg;
    assign alert_active_out    = st_reg.alert_act;
endmodule

// ===== tsa_top_assertions.sv
// Purpose: port checks for the sensor front end
// Assumes: alert and link outputs are registers
// Notes  : bound to every tsa_top
`timescale 1ns/10ps
module tsa_top_assertions (
    // System
    input wire logic        clock_in,
    input wire logic        sys_rst_in,
    // Link
    input wire logic        scl_clk_in,
    input wire logic        sda_out,
    input wire logic        sda_oe_out,
    // Converter and alert
    input wire logic        conv_start_out,
    input wire logic        alert_output_out,
    input wire logic        alert_output_oe_out,
    input wire logic [15:0] temp_out,
    input wire logic [7:0]  config_out,
    input wire logic        alert_active_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // Reset must see a released pin, so its own disable is off
    a_rst_idle: assert property (disable iff (1'b0)
        sys_rst_in |=> !alert_output_oe_out && !alert_active_out) else $error("alert in reset");
    a_pins_od: assert property (!alert_output_out && !sda_out)
        else $error("pin driven high");
    // Data may only move with clock low, else a false frame edge
    a_sda_clk: assert property ($changed(sda_oe_out) |-> !scl_clk_in)
        else $error("data moved with clock high");
    a_oe_pol: assert property ($changed(alert_active_out) |->
        alert_output_oe_out == (alert_active_out ^ config_out[2])) else $error("alert pin level");
    a_conv_once: assert property (conv_start_out |=> !conv_start_out)
        else $error("start pulse too long");
    a_start_free: assert property ($fell(sys_rst_in) |-> ##[0:2] conv_start_out)
        else $error("no start after reset");
    a_temp_pad: assert property (temp_out[3:0] == 4'h0)
        else $error("temperature pad bits set");
    a_alert_rise: assert property ($rose(alert_active_out) |->
        conv_start_out || $past(conv_start_out)) else $error("alert rose off a result");
    a_cmp_fall: assert property ($fell(alert_active_out) && !config_out[1] |->
        conv_start_out || $past(conv_start_out)) else $error("comparator alert fell early");
    a_temp_conv: assert property ($changed(temp_out) && !config_out[0] |-> conv_start_out)
        else $error("temperature moved off a result");
    c_alert: cover property ($rose(alert_active_out));
    c_ack: cover property ($rose(sda_oe_out));
    c_int_clr: cover property (config_out[1] && $fell(alert_active_out));
endmodule
bind tsa_top tsa_top_assertions u_chk (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .scl_clk_in(scl_clk_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .conv_start_out(conv_start_out), .alert_output_out(alert_output_out),
    .alert_output_oe_out(alert_output_oe_out), .temp_out(temp_out),
    .config_out(config_out), .alert_active_out(alert_active_out));

// ===== tsa_i2c_master.sv
// Purpose: two-wire bus master for the bench
// Assumes: pull-up on data, resolved by the bench
// Notes  : clock stands high between frames
`timescale 1ns/10ps
module tsa_i2c_master (
    // Wire
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_lo_out
);
    localparam int HALF = 20;
    logic tk = 1'b0;
    logic r;
    // 64 ns tick, 7 ns offset so it never meets a system edge
    initial begin
        scl_out = 1'b1;
        sda_lo_out = 1'b0;
        #7;
        forever #32 tk = ~tk;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge tk);
    endtask
    // Start when s, else stop; data moves well after clock falls
    task automatic cond(input logic s);
        ticks(4);
        sda_lo_out = !s;
        ticks(HALF - 4);
        scl_out = 1'b1;
        ticks(HALF);
        sda_lo_out = s;
        ticks(HALF);
        scl_out = !s;
    endtask
    task automatic bit_io(input logic b, output logic q);
        ticks(4);
        sda_lo_out = !b;
        ticks(HALF - 4);
        scl_out = 1'b1;
        ticks(HALF);
        q = sda_in;
        scl_out = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!mack, r);
    endtask
endmodule

// ===== tsa_top_tb.sv
// Purpose: bench for the sensor front end
// Assumes: straps at 5 except one address check, link paced by the master model
// Notes  : conversion base cut to 20 cycles
`timescale 1ns/10ps
module tsa_top_tb;
    import tsa_pkg::*;
`define CHK(a,b) begin compares++; if ((a)!==(b)) begin n_mismatch++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
    logic        clock_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [11:0] adc = 12'h3ff;
    logic [2:0]  strap = 3'h5;
    logic        scl, sda_lo, sda_oe, conv, oe_al, d_sda, d_al, act, ack;
    logic [15:0] temp, rd, th;
    logic [7:0]  cfg;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cyc = 0;
    wire         sda = !(sda_lo || sda_oe);
    tsa_top #(.CONV_BASE_CYCLES(20)) DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .scl_clk_in(scl), .sda_in(sda), .sda_out(d_sda), .sda_oe_out(sda_oe),
        .addr_strap_bit0_in(strap[0]), .addr_strap_bit1_in(strap[1]),
        .addr_strap_bit2_in(strap[2]),
        .conv_start_out(conv), .adc_data_in(adc), .alert_output_out(d_al),
        .alert_output_oe_out(oe_al), .temp_out(temp), .config_out(cfg),
        .alert_active_out(act));
    tsa_i2c_master M (.sda_in(sda), .scl_out(scl), .sda_lo_out(sda_lo));
    always #20 clock_in = ~clock_in;
    // Hang guard, well above the expected run
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic test_done();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wb(input logic [7:0] d, input logic exp);
        M.wbyte(d, ack);
        `CHK(ack, exp)
    endtask
    task automatic wreg(input logic [7:0] p, input logic [15:0] d, input logic two);
        M.cond(1'b1);
        wb(8'h9a, 1'b1);
        wb(p, 1'b1);
        if (two) wb(d[15:8], 1'b1);
        wb(d[7:0], 1'b1);
        M.cond(1'b0);
    endtask
    task automatic rreg(input logic [7:0] p);
        M.cond(1'b1);
        wb(8'h9a, 1'b1);
        wb(p, 1'b1);
        M.cond(1'b1);
        wb(8'h9b, 1'b1);
        M.rbyte(1'b1, rd[15:8]);
        M.rbyte(1'b0, rd[7:0]);
        M.cond(1'b0);
    endtask
    // New code lands just after a result, so the next one uses it
    task automatic setadc(input logic [11:0] x);
        @(posedge conv);
        @(posedge clock_in);
        adc <= x;
    endtask
    task automatic convs(input int n);
        repeat (n) @(posedge conv);
        repeat (2) @(posedge clock_in);
        #1;
    endtask
    initial begin
        repeat (20) @(posedge clock_in);
        #1;
        `CHK({cfg, temp, act, oe_al}, 26'h0)
        @(posedge clock_in) sys_rst_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        for (int r = 0; r < 4; r++) begin
            wreg(8'h01, {9'h000, r[1:0], 5'h00}, 1'b0);
            convs(2);
            `CHK(temp, 16'h3ff0 & (16'hfff0 << (3 - r)))
        end
        rreg(8'h00);
        `CHK(rd, 16'h3ff0)
        for (int p = 2; p < 4; p++) begin
            th = 16'h4a80 + 16'((p - 2) * 16'h0700);
            wreg(p[7:0], th, 1'b1);
            rreg(p[7:0]);
            `CHK(rd, th)
        end
        M.cond(1'b1);
        wb(8'h94, 1'b0);
        M.cond(1'b0);
        // Straps moved: the new address answers, the old one is refused
        @(posedge clock_in) strap <= 3'h2;
        M.cond(1'b1);
        wb(8'h94, 1'b1);
        M.cond(1'b0);
        M.cond(1'b1);
        wb(8'h9a, 1'b0);
        M.cond(1'b0);
        @(posedge clock_in) strap <= 3'h5;
        wreg(8'h01, 16'h0008, 1'b0);
        setadc(12'h520);
        convs(1);
        `CHK(act, 1'b0)
        convs(1);
        `CHK({act, oe_al}, 2'b11)
        setadc(12'h4c0);
        convs(1);
        `CHK(act, 1'b1)
        setadc(12'h4a0);
        convs(1);
        `CHK({act, oe_al}, 2'b00)
        wreg(8'h01, 16'h0004, 1'b0);
        convs(1);
        `CHK({act, oe_al}, 2'b01)
        wreg(8'h01, 16'h0002, 1'b0);
        setadc(12'h520);
        convs(2);
        `CHK(act, 1'b1)
        rreg(8'h01);
        `CHK({rd, act}, 17'h00404)
        convs(1);
        `CHK(act, 1'b0)
        setadc(12'h4a0);
        convs(1);
        `CHK(act, 1'b1)
        // Shutdown starts no new conversion, so wait on cycles, not on a start
        wreg(8'h01, 16'h0003, 1'b0);
        repeat (200) @(posedge clock_in);
        #1;
        `CHK({act, temp}, 17'h04a00)
        test_done();
    end
endmodule
